// file: design/id_table_map.vh
`ifndef ID_TABLE_MAP_VH
`define ID_TABLE_MAP_VH

// ----------------------------------------------------------------
// command opcodes
// ----------------------------------------------------------------
`define OP_READ_SERIAL_NUMBER   8'h4b
`define OP_READ_PARAM_TABLE     8'h5a

// ----------------------------------------------------------------
// framing counts, in serial clock edges or bytes
// ----------------------------------------------------------------
`define SINGLE_CLOCKS_PER_OP    4'h8
`define QUAD_CLOCKS_PER_OP      4'h2
`define SN_DUMMY_BYTES_3B       4'h4
`define SN_DUMMY_BYTES_4B       4'h5
`define PT_ADDR_BYTES           4'h3
`define PT_DUMMY_BYTES          4'h1
`define SN_BITS                 8'h80

// ----------------------------------------------------------------
// table header fields
// ----------------------------------------------------------------
`define SIG_B0                  8'h53
`define SIG_B1                  8'h46
`define SIG_B2                  8'h44
`define SIG_B3                  8'h50
`define HDR_MINOR_REV           8'h00
`define HDR_MAJOR_REV           8'h01
`define HDR_COUNT               8'h01
`define UNUSED_BYTE             8'hff
`define STD_TABLE_ID            8'h00
`define STD_TABLE_LEN           8'h09
`define STD_TABLE_PTR           8'h30
`define VND_TABLE_LEN           8'h03
`define VND_TABLE_PTR           8'h60

// ----------------------------------------------------------------
// standard parameter table bytes
// ----------------------------------------------------------------
`define PT_B30_ERASE_FLAGS      8'he5
`define PT_B31_ERASE_OP         8'h20
`define PT_B32_READ_FLAGS       8'hfb
`define PT_B33_UNUSED           8'hff
`define WAIT_144                5'h04
`define MODE_144                3'h2
`define OP_144                  8'heb
`define WAIT_114                5'h08
`define MODE_114                3'h0
`define OP_114                  8'h6b

`endif

// file: design/param_table_rom.v
`timescale 1ns/100ps
`include "id_table_map.vh"

// ------------------------------------------------------------------
// parameter table lookup, combinational, one byte per address
// ------------------------------------------------------------------
module param_table_rom (
  input  wire [7:0] addr,       // low table address byte
  input  wire [7:0] maker_id,   // maker code for second header
  input  wire [7:0] density_b0, // density word bytes, not decoded here
  input  wire [7:0] density_b1,
  input  wire [7:0] density_b2,
  input  wire [7:0] density_b3,
  output reg  [7:0] data        // table byte
);

  // table contents; unlisted addresses read as erased ones
  always @* begin
    case (addr)
      8'h00: data = `SIG_B0;
      8'h01: data = `SIG_B1;
      8'h02: data = `SIG_B2;
      8'h03: data = `SIG_B3;
      8'h04: data = `HDR_MINOR_REV;
      8'h05: data = `HDR_MAJOR_REV;
      8'h06: data = `HDR_COUNT;
      8'h07: data = `UNUSED_BYTE;
      8'h08: data = `STD_TABLE_ID;
      8'h09: data = `HDR_MINOR_REV;
      8'h0a: data = `HDR_MAJOR_REV;
      8'h0b: data = `STD_TABLE_LEN;
      8'h0c: data = `STD_TABLE_PTR;
      8'h0d: data = 8'h00;
      8'h0e: data = 8'h00;
      8'h0f: data = `UNUSED_BYTE;
      8'h10: data = maker_id;
      8'h11: data = `HDR_MINOR_REV;
      8'h12: data = `HDR_MAJOR_REV;
      8'h13: data = `VND_TABLE_LEN;
      8'h14: data = `VND_TABLE_PTR;
      8'h15: data = 8'h00;
      8'h16: data = 8'h00;
      8'h17: data = `UNUSED_BYTE;
      8'h30: data = `PT_B30_ERASE_FLAGS;
      8'h31: data = `PT_B31_ERASE_OP;
      8'h32: data = `PT_B32_READ_FLAGS;
      8'h33: data = `PT_B33_UNUSED;
      8'h34: data = density_b0;
      8'h35: data = density_b1;
      8'h36: data = density_b2;
      8'h37: data = density_b3;
      // nonzero wait fields mean dummy clocks are supported
      8'h38: data = {`MODE_144, `WAIT_144};
      8'h39: data = `OP_144;
      8'h3a: data = {`MODE_114, `WAIT_114};
      8'h3b: data = `OP_114;
      default: data = `UNUSED_BYTE;
    endcase
  end

endmodule // param_table_rom

// file: design/unique_id_and_param_table_read.v
`timescale 1ns/100ps
`include "id_table_map.vh"

module unique_id_and_param_table_read #(
  parameter [127:0] SERIAL_NUMBER = 128'h0123456789abcdef0fedcba987654321,
  parameter [7:0]   MAKER_ID      = 8'h5c,  // arbitrary neutral value
  parameter [31:0]  DENSITY       = 32'hffffffff
) (
  input  wire        mclk,
  input  wire        resetn,
  input  wire        cs_n,           // chip select pin, active low
  input  wire        sclk,           // serial clock pin
  input  wire [3:0]  sio_in,         // data pins in, sio_in[0] is si
  input  wire        quad_command_framing, // quad command mode level
  input  wire        addr4_mode,     // four-byte address mode level
  output reg  [3:0]  sio_out,        // data pins out, sio_out[1] is so
  output reg  [3:0]  sio_oe_n,       // low while driving the pin
  output reg         busy            // command in progress
);

  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  localparam [2:0] ST_IDLE  = 3'h0;  // waiting for select
  localparam [2:0] ST_OPC   = 3'h1;  // shifting in opcode
  localparam [2:0] ST_ADDR  = 3'h2;  // table address bytes
  localparam [2:0] ST_DUMMY = 3'h3;  // dummy bytes
  localparam [2:0] ST_DATA  = 3'h4;  // driving data
  localparam [2:0] ST_DONE  = 3'h5;  // ignore until select rises

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  reg [1:0] cs_sync_reg;     // select, two stages
  reg [1:0] clk_sync_reg;    // serial clock, two stages
  reg [3:0] sio_s1_reg;      // data pins, first stage
  reg [3:0] sio_s2_reg;      // data pins, second stage
  reg       clk_prev_reg;    // last synchronised clock level

  // two stages before any logic reads the pins
  always @(posedge mclk) begin
    if (!resetn) begin
      cs_sync_reg  <= 2'h3;
      clk_sync_reg <= 2'h0;
      sio_s1_reg   <= 4'h0;
      sio_s2_reg   <= 4'h0;
      clk_prev_reg <= 1'b0;
    end else begin
      cs_sync_reg  <= {cs_sync_reg[0], cs_n};
      clk_sync_reg <= {clk_sync_reg[0], sclk};
      sio_s1_reg   <= sio_in;
      sio_s2_reg   <= sio_s1_reg;
      clk_prev_reg <= clk_sync_reg[1];
    end
  end

  wire cs_low   = ~cs_sync_reg[1];                    // selected
  wire rise     = clk_sync_reg[1] & ~clk_prev_reg;    // sample edge
  wire fall     = ~clk_sync_reg[1] & clk_prev_reg;    // launch edge

  // ----------------------------------------------------------------
  // command engine
  // ----------------------------------------------------------------
  reg  [2:0]   state_reg;     // engine state
  reg  [7:0]   shift_reg;     // incoming byte
  reg  [3:0]   bit_cnt_reg;   // edges into current byte
  reg  [3:0]   byte_cnt_reg;  // bytes into current phase
  reg          is_sn_reg;     // serial number command active
  reg          quad_reg;      // framing latched at opcode start
  reg  [23:0]  addr_reg;      // table address
  reg  [7:0]   out_byte_reg;  // byte being shifted out
  reg  [2:0]   out_bit_reg;   // index of next bit out
  reg  [7:0]   sn_left_reg;   // serial number bits left
  reg  [127:0] sn_shift_reg;  // serial number out shifter
  wire [7:0]   rom_data;      // table byte at address
  wire [3:0]   dummy_need;    // dummy bytes for this command

  // the serial number comes only from the parameter, no write path
  wire [127:0] sn_value = SERIAL_NUMBER;

  // quad framing moves four bits per edge
  wire [3:0] edges_per_byte = quad_reg ? `QUAD_CLOCKS_PER_OP
                                       : `SINGLE_CLOCKS_PER_OP;
  wire [7:0] in_byte = quad_reg ? {shift_reg[3:0], sio_s2_reg}
                                : {shift_reg[6:0], sio_s2_reg[0]};
  wire       byte_done = (bit_cnt_reg == edges_per_byte - 4'h1);

  assign dummy_need = is_sn_reg ? (addr4_mode ? `SN_DUMMY_BYTES_4B
                                              : `SN_DUMMY_BYTES_3B)
                                : `PT_DUMMY_BYTES;

  // address above the table window reads as erased bytes
  param_table_rom u_rom (
    .addr       (addr_reg[7:0]),
    .maker_id   (MAKER_ID),
    .density_b0 (DENSITY[7:0]),
    .density_b1 (DENSITY[15:8]),
    .density_b2 (DENSITY[23:16]),
    .density_b3 (DENSITY[31:24]),
    .data       (rom_data)
  );
  wire [7:0] table_byte = (addr_reg[23:8] == 16'h0000) ? rom_data
                                                       : `UNUSED_BYTE;

  // state machine; select high always returns to idle
  always @(posedge mclk) begin
    if (!resetn) begin
      state_reg    <= ST_IDLE;
      shift_reg    <= 8'h00;
      bit_cnt_reg  <= 4'h0;
      byte_cnt_reg <= 4'h0;
      is_sn_reg    <= 1'b0;
      quad_reg     <= 1'b0;
      addr_reg     <= 24'h000000;
      out_byte_reg <= 8'h00;
      out_bit_reg  <= 3'h0;
      sn_left_reg  <= 8'h00;
      sn_shift_reg <= 128'h0;
      sio_out      <= 4'h0;
      sio_oe_n     <= 4'hf;
      busy         <= 1'b0;
    end else if (!cs_low) begin
      // abort at any point, pins released at once
      state_reg    <= ST_IDLE;
      sio_oe_n     <= 4'hf;
      busy         <= 1'b0;
      bit_cnt_reg  <= 4'h0;
      byte_cnt_reg <= 4'h0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          quad_reg <= quad_command_framing;
          busy     <= 1'b1;
          state_reg <= ST_OPC;
        end
        ST_OPC: begin
          if (rise) begin
            shift_reg   <= in_byte;
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
            if (byte_done) begin
              bit_cnt_reg <= 4'h0;
              if (in_byte == `OP_READ_SERIAL_NUMBER) begin
                is_sn_reg <= 1'b1;
                state_reg <= ST_DUMMY;
              end else if (in_byte == `OP_READ_PARAM_TABLE) begin
                is_sn_reg <= 1'b0;
                state_reg <= ST_ADDR;
              end else begin
                // other commands belong to other blocks
                state_reg <= ST_DONE;
              end
            end
          end
        end
        ST_ADDR: begin
          if (rise) begin
            shift_reg   <= in_byte;
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
            if (byte_done) begin
              bit_cnt_reg  <= 4'h0;
              addr_reg     <= {addr_reg[15:0], in_byte};
              byte_cnt_reg <= byte_cnt_reg + 4'h1;
              if (byte_cnt_reg == `PT_ADDR_BYTES - 4'h1) begin
                byte_cnt_reg <= 4'h0;
                state_reg    <= ST_DUMMY;
              end
            end
          end
        end
        ST_DUMMY: begin
          if (rise) begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
            if (byte_done) begin
              bit_cnt_reg  <= 4'h0;
              byte_cnt_reg <= byte_cnt_reg + 4'h1;
              if (byte_cnt_reg == dummy_need - 4'h1) begin
                byte_cnt_reg <= 4'h0;
                state_reg    <= ST_DATA;
                sn_shift_reg <= sn_value;
                sn_left_reg  <= `SN_BITS;
                out_byte_reg <= table_byte;
                out_bit_reg  <= 3'h7;
              end
            end
          end
        end
        ST_DATA: begin
          // drive on falling edges, host samples on rising edges
          if (fall) begin
            sio_oe_n <= 4'hd;
            if (is_sn_reg) begin
              if (sn_left_reg == 8'h00) begin
                // all 128 bits sent, release the pin
                sio_oe_n  <= 4'hf;
                state_reg <= ST_DONE;
              end else begin
                sio_out      <= {2'h0, sn_shift_reg[127], 1'b0};
                sn_shift_reg <= {sn_shift_reg[126:0], 1'b0};
                sn_left_reg  <= sn_left_reg - 8'h01;
              end
            end else begin
              sio_out <= {2'h0, out_byte_reg[out_bit_reg], 1'b0};
              out_bit_reg <= out_bit_reg - 3'h1;
              if (out_bit_reg == 3'h0) begin
                // next byte, address wraps over its full width
                addr_reg <= addr_reg + 24'h000001;
              end
            end
          end
          if (!is_sn_reg && out_bit_reg == 3'h7 && !fall) begin
            out_byte_reg <= table_byte;
          end
        end
        ST_DONE: begin
          sio_oe_n <= 4'hf;
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // unique_id_and_param_table_read

// file: verification/id_read_properties.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// port checker for the serial number and parameter table reader
// ----------------------------------------------------------------
module id_read_properties (
  input wire       mclk,
  input wire       resetn,
  input wire       cs_n,
  input wire       sclk,
  input wire [3:0] sio_out,
  input wire [3:0] sio_oe_n,
  input wire       busy
);
  reg       sclk_prev_reg;  // raw serial clock one mclk ago
  reg [7:0] rises_reg;      // raw clock rises in this frame, saturating
  // counts ahead of the synchroniser, so the early-drive bound is safe
  always @(posedge mclk) begin
    sclk_prev_reg <= sclk;
    if (!resetn || cs_n) rises_reg <= 8'h00;
    else if (sclk && !sclk_prev_reg && rises_reg != 8'hff)
      rises_reg <= rises_reg + 8'h01;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  sequence s_sel_high; cs_n [*5]; endsequence
  sequence s_sel_low; !cs_n [*5]; endsequence
  a_idle_released: assert property (s_sel_high |->
    sio_oe_n == 4'hf && !busy)
    else $error("pin driven or busy while deselected");
  a_busy_in_frame: assert property (s_sel_low |-> busy)
    else $error("busy low inside a frame");
  a_lanes_quiet: assert property (
    sio_oe_n[0] && sio_oe_n[3:2] == 2'h3)
    else $error("unused data lane driven");
  a_no_early_drive: assert property (
    !cs_n && rises_reg < 8'h0a |-> sio_oe_n[1])
    else $error("output driven in request phase");
  a_drive_after_fall: assert property (
    $fell(sio_oe_n[1]) |-> !sclk && !cs_n)
    else $error("drive started off a falling clock");
  a_bit_holds_high: assert property (
    sclk && $past(sclk) && !sio_oe_n[1] |-> $stable(sio_out[1]))
    else $error("data changed while clock high");
  a_release_on_deselect: assert property (
    $rose(cs_n) |-> ##[1:4] sio_oe_n == 4'hf)
    else $error("pin not released after deselect");
  a_reset_quiet: assert property (
    $rose(resetn) |-> sio_oe_n == 4'hf && !busy)
    else $error("outputs active right after reset");
  a_drive_in_frame: assert property (
    !sio_oe_n[1] |-> busy || $past(busy))
    else $error("pin driven outside a command");
endmodule // id_read_properties
bind unique_id_and_param_table_read id_read_properties id_read_properties_inst (
  .mclk(mclk), .resetn(resetn), .cs_n(cs_n), .sclk(sclk),
  .sio_out(sio_out), .sio_oe_n(sio_oe_n), .busy(busy));

// file: verification/flash_host_model.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// host controller model: select, serial clock and request lanes
// ----------------------------------------------------------------
module flash_host_model (
  input  wire       mclk,
  input  wire [3:0] sio_out,
  input  wire [3:0] sio_oe_n,
  output reg        cs_n,
  output reg        sclk,
  output reg  [3:0] sio_in
);
  reg  quad_reg;   // framing of the open frame
  reg  early_reg;  // device drove during the request phase
  reg  last_reg;   // last level driven on the data-out line
  reg  odd_reg;    // alternates 6 and 7 cycle highs for 125 ns
  wire so_line;    // data-out line as the host sees it
  // a released line shows the inverse of its last level, never a copy
  assign so_line = sio_oe_n[1] ? ~last_reg : sio_out[1];
  always @(posedge mclk) begin
    if (!sio_oe_n[1]) last_reg <= sio_out[1];
  end
  initial begin
    {cs_n, sclk, sio_in} = 6'h20;
    {quad_reg, early_reg, last_reg, odd_reg} = 4'h0;
  end
  // one clock: lanes set on the low half, data-out sampled at the rise
  task automatic tick(input [3:0] d, output s, output r);
    begin
      sclk = 1'b0;
      sio_in = d;
      repeat (6) @(negedge mclk);
      sclk = 1'b1;
      s = so_line;
      r = sio_oe_n[1];
      odd_reg = ~odd_reg;
      repeat (odd_reg ? 7 : 6) @(negedge mclk);
    end
  endtask
  // one request byte: eight clocks on one lane, or two on four
  task automatic send(input [7:0] v);
    reg s, r;
    integer k;
    begin
      for (k = 0; k < (quad_reg ? 2 : 8); k = k + 1) begin
        if (quad_reg) tick(k ? v[3:0] : v[7:4], s, r);
        else tick({3'h0, v[7 - k]}, s, r);
        if (!r) early_reg = 1'b1;
      end
    end
  endtask
  // one data byte, first bit received is the most significant
  task automatic recv(output [7:0] v);
    reg s, r;
    integer k;
    begin
      for (k = 7; k >= 0; k = k - 1) begin
        tick(4'hf, s, r);
        v[k] = s;
      end
    end
  endtask
  task automatic open(input q);
    begin
      quad_reg = q;
      early_reg = 1'b0;
      @(negedge mclk) cs_n = 1'b0;
    end
  endtask
  // select rises with the clock low; may cut a byte short
  task automatic close;
    begin
      sclk = 1'b0;
      repeat (6) @(negedge mclk);
      cs_n = 1'b1;
      repeat (12) @(negedge mclk);
    end
  endtask
endmodule // flash_host_model

// file: verification/unique_id_and_param_table_read_bench.sv
`timescale 1ns/100ps
module unique_id_and_param_table_read_bench;
  localparam [127:0] SN = 128'h6a3f9e01c47d28b5113ce9a05f72d84b;
  localparam [7:0]   MK = 8'h3a; // arbitrary maker code
  reg         mclk, resetn, quad_command_framing, addr4_mode;
  wire        cs_n, sclk, busy;
  wire [3:0]  sio_in, sio_out, sio_oe_n;
  integer     n_errors, checks, cycles, seed, i, k;
  reg [7:0]   b;
  reg [127:0] sn;
  reg         s, r;
  reg [23:0]  a;
  unique_id_and_param_table_read #(.SERIAL_NUMBER(SN), .MAKER_ID(MK))
    unique_id_and_param_table_read_inst (.mclk(mclk), .resetn(resetn),
    .cs_n(cs_n), .sclk(sclk), .sio_in(sio_in), .addr4_mode(addr4_mode),
    .quad_command_framing(quad_command_framing), .sio_out(sio_out),
    .sio_oe_n(sio_oe_n), .busy(busy));
  flash_host_model flash_host_model_inst (.mclk(mclk), .sio_out(sio_out),
    .sio_oe_n(sio_oe_n), .cs_n(cs_n), .sclk(sclk), .sio_in(sio_in));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // ----------------------------------------------------------------
  // expected table byte; anything not listed reads all ones
  // ----------------------------------------------------------------
  function [7:0] tab(input [23:0] ad);
    begin
      tab = 8'hff;                                 // erased default
      if (ad[23:8] == 16'h0) begin
        case (ad[7:0])
          8'h00: tab = 8'h53;
          8'h01: tab = 8'h46;
          8'h02: tab = 8'h44;
          8'h03: tab = 8'h50;
          8'h05: tab = 8'h01;
          8'h06: tab = 8'h01;
          8'h0a: tab = 8'h01;
          8'h0b: tab = 8'h09;
          8'h0c: tab = 8'h30;
          8'h10: tab = MK;
          8'h12: tab = 8'h01;
          8'h13: tab = 8'h03;
          8'h14: tab = 8'h60;
          8'h04, 8'h08, 8'h09, 8'h0d: tab = 8'h00;
          8'h0e, 8'h11, 8'h15, 8'h16: tab = 8'h00;
          8'h30: tab = 8'he5;
          8'h31: tab = 8'h20;
          8'h32: tab = 8'hfb;
          8'h38: tab = 8'h44;
          8'h39: tab = 8'heb;
          8'h3a: tab = 8'h08;
          8'h3b: tab = 8'h6b;
          default: tab = 8'hff;
        endcase
      end
    end
  endfunction
  task cmp_byte(input [7:0] got, input [7:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("FAIL t=%0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task cmp_sn(input [127:0] got, input [127:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("FAIL t=%0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task cmp_bit(input got, input exp);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("FAIL t=%0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task sn_read(input q, input a4);
    begin
      @(negedge mclk);
      quad_command_framing = q;
      addr4_mode = a4;
      flash_host_model_inst.open(q);
      flash_host_model_inst.send(8'h4b);
      for (k = 0; k < (a4 ? 5 : 4); k = k + 1) begin
        b = $random(seed);
        flash_host_model_inst.send(b);
      end
      for (k = 127; k >= 0; k = k - 1) begin
        flash_host_model_inst.tick(4'hf, s, r);
        sn[k] = s;
      end
      flash_host_model_inst.tick(4'hf, s, r);
      flash_host_model_inst.close;
      cmp_sn(sn, SN);
      cmp_bit(r, 1'b1);
      cmp_bit(flash_host_model_inst.early_reg, 1'b0);
    end
  endtask
  // table read; cut extra clocks abort in mid-byte
  task tab_read(input q, input [23:0] st, input integer n, input integer cut);
    begin
      @(negedge mclk);
      quad_command_framing = q;
      flash_host_model_inst.open(q);
      flash_host_model_inst.send(8'h5a);
      for (k = 16; k >= 0; k = k - 8) flash_host_model_inst.send(st[k +: 8]);
      b = $random(seed);
      flash_host_model_inst.send(b);
      for (k = 0; k < n; k = k + 1) begin
        flash_host_model_inst.recv(b);
        cmp_byte(b, tab(st + k[23:0]));
      end
      repeat (cut) flash_host_model_inst.tick(4'hf, s, r);
      flash_host_model_inst.close;
      cmp_bit(sio_oe_n === 4'hf && busy === 1'b0, 1'b1);
      cmp_bit(flash_host_model_inst.early_reg, 1'b0);
    end
  endtask
  task close_out;
    begin
      $display("checks %0d n_errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  // hang guard, well above the roughly 19400 cycles of the run
  always @(posedge mclk) begin
    cycles = cycles + 1;
    if (cycles == 60000) begin
      n_errors = n_errors + 1;
      close_out;
    end
  end
  initial begin
    {resetn, quad_command_framing, addr4_mode} = 3'h0;
    {n_errors, checks, cycles} = 0;
    seed = 32'h5d0e;
    repeat (5) @(negedge mclk);
    resetn = 1'b1;
    for (i = 0; i < 4; i = i + 1) sn_read(i[0], i[1]);
    // reset pulsed inside a frame: pins stay released, engine restarts
    quad_command_framing = 1'b0;
    flash_host_model_inst.open(1'b0);
    flash_host_model_inst.send(8'h4b);
    resetn = 1'b0;
    repeat (5) @(negedge mclk);
    resetn = 1'b1;
    repeat (2) @(negedge mclk);
    cmp_bit(sio_oe_n === 4'hf && busy === 1'b0, 1'b1);
    flash_host_model_inst.close;
    tab_read(1'b0, 24'h0, 64, 0);
    for (i = 0; i < 4; i = i + 1) begin
      a = $random(seed);
      tab_read(i[0], (i == 3) ? a : {18'h0, a[5:0]}, 6, a[8:6]);
    end
    // unknown opcode: the data pin stays released to the end
    // framing level must match the host, or the opcode is misframed
    quad_command_framing = 1'b0;
    flash_host_model_inst.open(1'b0);
    repeat (5) flash_host_model_inst.send(8'h3c);
    flash_host_model_inst.close;
    cmp_bit(flash_host_model_inst.early_reg, 1'b0);
    close_out;
  end
endmodule // unique_id_and_param_table_read_bench
